// >>> bench/bps_asserts.sv
// assertions on the supervisor top ports
// assumes binding into bps_supervisor, one clock domain
`timescale 1ns/1ns
module bps_sva (
	// clock, reset, supply
	input wire logic clk_sys_in,
	input wire logic reset_n_in,
	input wire logic input_undervolt_lockout_in,
	input wire logic thermal_shutdown_in,
	input wire logic force_pwm_in,
	// levels and comparators
	input wire logic [1:0] chan_enable_softstart_on_in,
	input wire logic undervolt_delay_cap_present_in,
	input wire logic [1:0] overvoltage_in,
	input wire logic [1:0] switch_node_below_ilim_in,
	input wire logic [1:0] neg_limit_in,
	// outputs watched
	input wire logic [1:0] top_on_out,
	input wire logic [1:0] bot_on_out,
	input wire logic undervolt_delay_charge_out,
	input wire logic shutdown_latch_out,
	input wire logic power_ok_out,
	input wire logic power_ok_oe_n_out
);
	default clocking @(posedge clk_sys_in); endclocking
	default disable iff (!reset_n_in);
	wire ok = !input_undervolt_lockout_in && !thermal_shutdown_in;
	wire lat = shutdown_latch_out;
	AST_OV_LATCH: assert property (
		overvoltage_in[1] && ok && |chan_enable_softstart_on_in ##1 ok
		|-> ##1 lat) else $error("overvoltage did not latch");
	AST_LATCH_GATES: assert property (
		lat [*2] |-> top_on_out == 2'h0 && bot_on_out == 2'h3)
		else $error("latch gates wrong");
	AST_FAULT_CLEAR: assert property (
		!ok [*2] |-> ##1 !lat) else $error("fault kept latch");
	AST_PG_LATCH: assert property (
		lat [*2] |-> !power_ok_oe_n_out) else $error("power ok free in latch");
	AST_PG_PIN: assert property (
		power_ok_out == 1'h0) else $error("power ok driven high");
	AST_UV_OFF: assert property (
		!undervolt_delay_cap_present_in [*3] |-> !undervolt_delay_charge_out)
		else $error("charge without delay cap");
	AST_ILIM: assert property (
		top_on_out[1] [*4] ##0 switch_node_below_ilim_in[1]
		|-> ##[1:2] !top_on_out[1]) else $error("current limit ignored");
	AST_NEG_LIMIT: assert property (
		ok && chan_enable_softstart_on_in[0] && !lat ##1
		bot_on_out[0] && neg_limit_in[0] && force_pwm_in && ok && !lat
		&& chan_enable_softstart_on_in[0] ##1 !lat
		|-> ##[0:1] !bot_on_out[0]) else $error("negative limit ignored");
	cover property (lat ##1 !lat);
	cover property (undervolt_delay_charge_out);
	cover property ($rose(top_on_out[0]));
endmodule : bps_sva

bind bps_supervisor bps_sva i_sva (.*);

// >>> bench/bps_stage_model.sv
// power stage model: switches and current comparators, two channels
// assumes gate commands from the supervisor on the same clock
`timescale 1ns/1ns
module bps_stage_model (
	// clock
	input wire logic clk_sys_in,
	// gate commands and load
	input wire logic [1:0] top_on_in,
	input wire logic [1:0] bot_on_in,
	input wire logic [1:0] overload_in,
	// comparators
	output logic [1:0] pwm_end_out,
	output logic [1:0] ilim_out,
	output logic [1:0] neg_limit_out
);
	logic [3:0] ton_q [2] = '{4'h0, 4'h0};
	logic [3:0] bon_q [2] = '{4'h0, 4'h0};
	always_ff @(posedge clk_sys_in) begin
		for (int i = 0; i < 2; i++) begin
			ton_q[i] <= top_on_in[i] ? ton_q[i] + 4'h1 : 4'h0;
			bon_q[i] <= (bot_on_in[i] && bon_q[i] != 4'hF) ? bon_q[i] + 4'h1 : 4'h0;
		end
	end
	// early end on purpose: only blanking keeps the pulse alive
	always_comb begin
		for (int i = 0; i < 2; i++) begin
			pwm_end_out[i] = ton_q[i] >= 4'h2;
			ilim_out[i] = overload_in[i] && top_on_in[i];
			neg_limit_out[i] = bon_q[i] >= 4'h9;
		end
	end
endmodule : bps_stage_model

// >>> bench/tb.sv
// self-checking bench for the buck protection supervisor
// assumes bps_stage_model as power stage and a 20 MHz clock
`timescale 1ns/1ns
module tb;
	import bps_pkg::*;
	logic clk = 1'h0;
	logic rst_n = 1'h0;
	logic input_undervolt_lockout = 1'h0, therm = 1'h0, fpwm = 1'h1, cap = 1'h0;
	logic trip = 1'h0, below = 1'h0, t0 = 1'h0, mon = 1'h0;
	logic [1:0] en = 2'h0, low = 2'h0, tmo = 2'h0, ov = 2'h0, ovl = 2'h0;
	logic [2:0] uv = 3'h0, pgl = 3'h0;
	logic [4:0] code = 5'h0;
	logic [15:0] vin = 16'h2EE0;
	logic [1:0] pe, il, ng, top, bot;
	logic lat, trn, chg, oen, pok, lin_en, lin_rst;
	logic seen = 1'h0;
	logic [15:0] vins [5] = '{16'h2EE0, 16'h4268, 16'h4269, 16'h4E20, 16'h7530};
	int err_total = 0, checked = 0, hi = 0, per = 0;
	bps_supervisor i_dut (.clk_sys_in(clk), .reset_n_in(rst_n),
		.vin_mv_in(vin), .input_undervolt_lockout_in(input_undervolt_lockout),
		.thermal_shutdown_in(therm), .force_pwm_in(fpwm),
		.chan_enable_softstart_on_in(en), .chan_enable_softstart_low_in(low),
		.chan_enable_softstart_timeout_in(tmo),
		.undervolt_delay_cap_present_in(cap),
		.undervolt_delay_cap_tripped_in(trip), .overvoltage_in(ov),
		.undervoltage_in(uv), .below_power_ok_out_low_in(pgl),
		.above_power_ok_out_recover_in(~pgl), .pwm_end_in(pe),
		.switch_node_below_ilim_in(il), .neg_limit_in(ng),
		.voltage_code_in(code), .ch1_below_new_target_in(below),
		.top_on_out(top), .bot_on_out(bot), .linear_enable_out(lin_en),
		.linear_reset_out(lin_rst), .undervolt_delay_charge_out(chg),
		.voltage_code_transition_out(trn), .shutdown_latch_out(lat),
		.power_ok_out(pok), .power_ok_oe_n_out(oen));
	bps_stage_model i_stage (.clk_sys_in(clk), .top_on_in(top),
		.bot_on_in(bot), .overload_in(ovl), .pwm_end_out(pe),
		.ilim_out(il), .neg_limit_out(ng));
	initial forever #25 clk = ~clk;
	task automatic cmp(input logic [7:0] got, input logic [7:0] exp, string s);
		checked++;
		if (got !== exp) begin
			err_total++;
			$display("mismatch at %0t: %s got %h want %h", $time, s, got, exp);
		end
	endtask : cmp
	task automatic tick(input int n);
		repeat (n) @(posedge clk);
	endtask : tick
	task automatic end_of_test();
		$display("comparisons %0d mismatches %0d", checked, err_total);
		if (err_total == 0 && checked > 0) $display("Test passed");
		else $display("Test failed");
		$finish;
	endtask : end_of_test
	function automatic int exp_per(input logic [15:0] v);
		if (v <= VIN_KNEE_MV) return NOM_PERIOD_CYCLES;
		return NOM_PERIOD_CYCLES * int'(v) / VIN_KNEE_MV;
	endfunction : exp_per
	// one cycle of slack: the rounding of the scaled period is open
	always @(posedge clk) begin
		t0 <= top[0];
		hi <= top[0] ? hi + 1 : 0;
		per <= (top[0] && !t0) ? 1 : per + 1;
		if (mon && t0 && !top[0])
			cmp(hi >= BLANK_CYCLES, 8'h1, "blank");
		if (mon && top[0] && !t0)
			cmp((per - exp_per(vin)) inside {[-1:1]}, 8'h1, "period");
	end
	initial begin
		#400000;
		err_total++;
		$display("mismatch at %0t: timeout", $time);
		end_of_test();
	end
	initial begin
		void'($urandom(32'hA8CD));
		tick(1);
		@(negedge clk);
		cmp({top, bot, lat, oen}, 8'h0C, "reset");
		tick(1);
		rst_n <= 1'h1;
		en <= 2'h3;
		tmo <= 2'h3;
		cap <= 1'h1;
		tick(6);
		@(negedge clk);
		cmp(oen, 8'h1, "pg free");
		for (int k = 0; k < 6; k++) begin
			tick(1);
			vin <= vins[$urandom % 5];
			ovl <= 2'($urandom) & 2'h2;
			tick(200);
			mon <= 1'h1;
			tick(400);
			mon <= 1'h0;
		end
		$display("test switching done");
		ovl <= 2'h0;
		fpwm <= 1'($urandom);
		ov <= 2'h2;
		tick(1);
		ov <= 2'h0;
		tick(3);
		@(negedge clk);
		cmp({lat, oen, top, bot}, 8'h23, "ov latch");
		cmp({lin_en, lin_rst}, 8'h2, "lin in latch");
		tick(1);
		en <= 2'h0;
		low <= 2'h3;
		tmo <= 2'h0;
		tick(4);
		low <= 2'h0;
		en <= 2'h3;
		tmo <= 2'h3;
		tick(4);
		@(negedge clk);
		cmp(lat, 8'h0, "en release");
		$display("test latch done");
		tick(1);
		code <= 5'h05;
		tick(3);
		// bottom may be cut by the limit; it must come on within a period
		seen = 1'h0;
		repeat (150) begin
			@(negedge clk);
			seen = seen | bot[0];
		end
		cmp({trn, oen, top[0], seen}, 8'h9, "vid");
		tick(1);
		ov <= 2'h1;
		uv <= 3'h1;
		tick(4);
		@(negedge clk);
		cmp(lat, 8'h0, "ch1 masked");
		tick(1);
		ov <= 2'h0;
		uv <= 3'h0;
		below <= 1'h1;
		tick(4);
		@(negedge clk);
		cmp({trn, oen}, 8'h1, "vid end");
		$display("test vid done");
		tick(1);
		below <= 1'h0;
		cap <= 1'h0;
		uv <= 3'h2;
		tick(5);
		@(negedge clk);
		cmp({chg, lat}, 8'h0, "uv off");
		tick(1);
		cap <= 1'h1;
		tick(3);
		@(negedge clk);
		cmp(chg, 8'h1, "uv charge");
		tick(1);
		trip <= 1'h1;
		tick(3);
		@(negedge clk);
		cmp(lat, 8'h1, "uv latch");
		tick(1);
		trip <= 1'h0;
		uv <= 3'h0;
		therm <= 1'h1;
		tick(3);
		@(negedge clk);
		cmp({lat, oen}, 8'h0, "fault");
		cmp({lin_en, lin_rst}, 8'h1, "lin fault");
		tick(1);
		therm <= 1'h0;
		tmo <= 2'h0;
		uv <= 3'h4;
		tick(5);
		@(negedge clk);
		cmp(chg, 8'h0, "lin no timeout");
		tick(1);
		tmo <= 2'h1;
		tick(4);
		@(negedge clk);
		cmp(chg, 8'h1, "lin uv");
		tick(1);
		uv <= 3'h0;
		tmo <= 2'h3;
		pgl <= 3'($urandom_range(1, 7));
		tick(4);
		@(negedge clk);
		cmp(oen, 8'h0, "pg low");
		tick(1);
		pgl <= 3'h0;
		tick(4);
		@(negedge clk);
		cmp(oen, 8'h1, "pg back");
		$display("test protection done");
		end_of_test();
	end
endmodule : tb

// >>> core/bps_phase.sv
// one switching channel's gate-drive sequencing
// assumes cycle_start is a one-cycle pulse from the frequency generator
`timescale 1ns/1ns
module bps_phase
	import bps_pkg::*;
(
	// clock and reset
	input wire logic clk_sys_in,
	input wire logic reset_n_in,
	// control
	input wire logic cycle_start_in,
	input wire logic run_in,
	input wire logic hold_off_in,
	input wire logic neg_limit_en_in,
	input wire logic force_pwm_in,
	input wire logic discharge_in,
	input wire logic discharge_end_in,
	// comparators
	input wire logic pwm_end_in,
	input wire logic sw_below_ilim_in,
	input wire logic neg_limit_in,
	// gate drives
	output logic top_on_out,
	output logic bot_on_out
);
	typedef struct packed {
		logic top;
		logic bot;
		logic [7:0] blank;
		logic nl_off;
	} bps_ph_type;
	bps_ph_type q, d;

	always_comb begin
		d = q;
		if (!run_in || hold_off_in) begin
			d.top = 1'b0;
			d.bot = 1'b1;
			d.blank = '0;
			d.nl_off = 1'b0;
		end else if (discharge_in) begin
			d.top = 1'b0;
			if (discharge_end_in) begin
				d.bot = 1'b0;
				d.nl_off = 1'b0;
			end else if (q.bot && neg_limit_in) begin
				d.bot = 1'b0;
				d.nl_off = 1'b1;
			end else if (cycle_start_in || !q.nl_off) begin
				// bottom goes on at entry, and again each new cycle
				d.bot = 1'b1;
				d.nl_off = 1'b0;
			end
		end else if (cycle_start_in) begin
			d.top = 1'b1;
			d.bot = 1'b0;
			d.nl_off = 1'b0;
			d.blank = 8'(BLANK_CYCLES);
		end else if (q.top) begin
			if (q.blank != '0)
				d.blank = q.blank - 8'h01;
			else if (sw_below_ilim_in || pwm_end_in) begin
				d.top = 1'b0;
				d.bot = force_pwm_in;
			end
		end else if (q.bot && neg_limit_en_in && neg_limit_in) begin
			d.bot = 1'b0;
		end
	end

	always_ff @(posedge clk_sys_in or negedge reset_n_in) begin
		if (!reset_n_in)
			q <= '{top: 1'b0, bot: 1'b1, blank: 8'h00, nl_off: 1'b0};
		else
			q <= d;
	end

	assign top_on_out = q.top;
	assign bot_on_out = q.bot;
endmodule : bps_phase

// >>> core/bps_pkg.sv
// constants for the buck protection supervisor
// assumes a 20 MHz system clock and comparator levels already synchronous
package bps_pkg;
	localparam int CLK_HZ = 20000000;
	localparam int BLANK_NS = 160;
	// clock in MHz first: ns times Hz would overflow a 32-bit int
	localparam int BLANK_CYCLES = (BLANK_NS * (CLK_HZ / 1000000) + 999) / 1000;
	localparam int SW_FREQ_HZ = 250000;
	localparam int NOM_PERIOD_CYCLES = CLK_HZ / SW_FREQ_HZ;
	localparam int VIN_KNEE_MV = 17000;
	localparam int CNT_W = 16;
	localparam int VIN_W = 16;
endpackage : bps_pkg

// >>> core/bps_supervisor.sv
// top of the buck protection supervisor: latch, protection, power-good
// assumes all comparator levels are synchronous to clk_sys_in
`timescale 1ns/1ns
module bps_supervisor
	import bps_pkg::*;
#(
	parameter int VIN_MV_W = VIN_W
) (
	// clock and reset
	input wire logic clk_sys_in,
	input wire logic reset_n_in,
	// supply and mode
	input wire logic [VIN_MV_W-1:0] vin_mv_in,
	input wire logic input_undervolt_lockout_in,
	input wire logic thermal_shutdown_in,
	input wire logic force_pwm_in,
	// enable/soft-start pin levels per channel
	input wire logic [1:0] chan_enable_softstart_on_in,
	input wire logic [1:0] chan_enable_softstart_low_in,
	input wire logic [1:0] chan_enable_softstart_timeout_in,
	// undervoltage delay pin
	input wire logic undervolt_delay_cap_present_in,
	input wire logic undervolt_delay_cap_tripped_in,
	// output comparators: index 0 ch1, 1 ch2, 2 linear
	input wire logic [1:0] overvoltage_in,
	input wire logic [2:0] undervoltage_in,
	input wire logic [2:0] below_power_ok_out_low_in,
	input wire logic [2:0] above_power_ok_out_recover_in,
	// current comparators per switching channel
	input wire logic [1:0] pwm_end_in,
	input wire logic [1:0] switch_node_below_ilim_in,
	input wire logic [1:0] neg_limit_in,
	// channel 1 voltage code
	input wire logic [4:0] voltage_code_in,
	input wire logic ch1_below_new_target_in,
	// outputs
	output logic [1:0] top_on_out,
	output logic [1:0] bot_on_out,
	output logic linear_enable_out,
	output logic linear_reset_out,
	output logic undervolt_delay_charge_out,
	output logic voltage_code_transition_out,
	output logic shutdown_latch_out,
	output logic power_ok_out,
	output logic power_ok_oe_n_out
);
	initial begin
		// above 23 bits the stretched period overflows the counter
		if (VIN_MV_W < 15 || VIN_MV_W > 23)
			$error("bps_supervisor: VIN_MV_W out of range");
	end

	typedef struct packed {
		logic [1:0] overvoltage_trip;
		logic [2:0] undervoltage_trip;
		logic [2:0] low;
		logic [2:0] rec;
		logic [1:0] tmo;
		logic [1:0] on;
		logic [1:0] ens_low;
		logic fault;
		logic dcap;
		logic dtrip;
		logic latch;
		logic both_low_seen;
		logic trans;
		logic down;
		logic [4:0] code;
		logic code_valid;
		logic [2:0] pg_low;
		logic pg_n;
		logic uv_charge;
		logic lin_rst;
		logic [CNT_W-1:0] cnt;
		logic [CNT_W-1:0] period;
		logic start;
	} bps_sup_type;
	bps_sup_type q, d;

	// period in clock cycles, stretched by vin/17V above the knee
	function automatic logic [CNT_W-1:0] calc_period(
		input logic [VIN_MV_W-1:0] vin);
		logic [31:0] p;
		p = 32'(NOM_PERIOD_CYCLES);
		if (32'(vin) > 32'(VIN_KNEE_MV))
			p = (32'(NOM_PERIOD_CYCLES) * 32'(vin)) / 32'(VIN_KNEE_MV);
		return CNT_W'(p);
	endfunction : calc_period

	logic any_on, any_tmo, trip_ovp, trip_uvp, mask1;
	logic [1:0] neg_en;

	always_comb begin
		d = q;
		// registered inputs
		d.overvoltage_trip = overvoltage_in;
		d.undervoltage_trip = undervoltage_in;
		d.low = below_power_ok_out_low_in;
		d.rec = above_power_ok_out_recover_in;
		d.tmo = chan_enable_softstart_timeout_in;
		d.on = chan_enable_softstart_on_in;
		d.ens_low = chan_enable_softstart_low_in;
		d.fault = input_undervolt_lockout_in | thermal_shutdown_in;
		d.dcap = undervolt_delay_cap_present_in;
		d.dtrip = undervolt_delay_cap_tripped_in;

		// switching-cycle clock
		d.start = 1'b0;
		if (q.cnt == '0) begin
			d.period = calc_period(vin_mv_in);
			d.cnt = d.period - 1'b1;
			d.start = 1'b1;
		end else begin
			d.cnt = q.cnt - 1'b1;
		end

		any_on = |q.on;
		any_tmo = |q.tmo;
		mask1 = q.trans;
		trip_ovp = any_on && !q.fault &&
			(q.overvoltage_trip[1] || (q.overvoltage_trip[0] && !mask1));
		trip_uvp = q.dcap && !q.fault &&
			((q.undervoltage_trip[0] && q.on[0] && q.tmo[0] && !mask1) ||
			(q.undervoltage_trip[1] && q.on[1] && q.tmo[1]) ||
			(q.undervoltage_trip[2] && any_on && any_tmo));

		// delay capacitor charges while a trip stands and the latch is clear
		d.uv_charge = trip_uvp && !q.latch;

		// latch release by both enables low then released
		if (&q.ens_low)
			d.both_low_seen = 1'b1;
		else if (!(|q.ens_low))
			d.both_low_seen = 1'b0;
		if (q.fault) begin
			d.latch = 1'b0;
			d.uv_charge = 1'b0;
		end else if (trip_ovp || (q.uv_charge && q.dtrip)) begin
			d.latch = 1'b1;
		end else if (q.both_low_seen && !(|q.ens_low)) begin
			d.latch = 1'b0;
		end
		d.lin_rst = q.fault;

		// channel 1 voltage-code transition
		d.code_valid = 1'b1;
		d.code = voltage_code_in;
		if (!q.on[0] || q.fault || q.latch) begin
			d.trans = 1'b0;
			d.down = 1'b0;
		end else if (q.code_valid && voltage_code_in != q.code) begin
			d.trans = 1'b1;
			d.down = voltage_code_in > q.code; // higher code, lower volts
		end else if (q.trans && (ch1_below_new_target_in || !q.down)) begin
			d.trans = 1'b0;
			d.down = 1'b0;
		end

		// power-good with hysteresis on low outputs
		for (int i = 0; i < 3; i++) begin
			if (q.low[i])
				d.pg_low[i] = 1'b1;
			else if (q.rec[i])
				d.pg_low[i] = 1'b0;
		end
		d.pg_n = (|q.overvoltage_trip) || (|q.pg_low) || q.trans ||
			!any_on || q.fault || q.latch;
	end

	always_ff @(posedge clk_sys_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			q <= '0;
			q.pg_n <= 1'b1;
			q.fault <= 1'b1;
		end else begin
			q <= d;
		end
	end

	assign neg_en[0] = !force_pwm_in ? 1'b0 : 1'b1;
	assign neg_en[1] = neg_en[0];

	logic [1:0] ch_run;
	assign ch_run = q.on & {2{!q.fault}};

	bps_phase u_ch1 (
		.clk_sys_in(clk_sys_in),
		.reset_n_in(reset_n_in),
		.cycle_start_in(q.start),
		.run_in(ch_run[0]),
		.hold_off_in(q.latch),
		.neg_limit_en_in(force_pwm_in || q.trans),
		.force_pwm_in(force_pwm_in),
		.discharge_in(q.trans && q.down),
		.discharge_end_in(ch1_below_new_target_in),
		.pwm_end_in(pwm_end_in[0]),
		.sw_below_ilim_in(switch_node_below_ilim_in[0]),
		.neg_limit_in(neg_limit_in[0]),
		.top_on_out(top_on_out[0]),
		.bot_on_out(bot_on_out[0])
	);

	bps_phase u_ch2 (
		.clk_sys_in(clk_sys_in),
		.reset_n_in(reset_n_in),
		.cycle_start_in(q.start),
		.run_in(ch_run[1]),
		.hold_off_in(q.latch),
		.neg_limit_en_in(neg_en[1]),
		.force_pwm_in(force_pwm_in),
		.discharge_in(1'b0),
		.discharge_end_in(1'b0),
		.pwm_end_in(pwm_end_in[1]),
		.sw_below_ilim_in(switch_node_below_ilim_in[1]),
		.neg_limit_in(neg_limit_in[1]),
		.top_on_out(top_on_out[1]),
		.bot_on_out(bot_on_out[1])
	);

	// linear channel keeps running through the latch
	assign linear_enable_out = any_on && !q.fault;
	assign linear_reset_out = q.lin_rst;
	assign undervolt_delay_charge_out = q.uv_charge;
	assign voltage_code_transition_out = q.trans;
	assign shutdown_latch_out = q.latch;
	assign power_ok_out = 1'b0;
	assign power_ok_oe_n_out = !q.pg_n;
endmodule : bps_supervisor
